/* File: rtl/rf_event_mask_pkg.sv */
// Function
// - Eight-bit mask register at 0x61A3, resets disabled
// - Bit 7 gates receive-enable cleared event
// - Bit 6 gates frame received event
// - Bit 5 gates frame filter pass event
// - Bit 2 gates receive queue level event
// - Bit 1 gates delimiter seen event
package rf_event_mask_pkg;
  localparam int EVENT_COUNT = 8;
  // Printed offsets are not word multiples, so byte address is four times index
  localparam logic [15:0] MASK_INDEX = 16'h61A3;
  localparam logic [15:0] FLAG_INDEX = 16'h61A6;
  localparam logic [17:0] MASK_ADDR = {MASK_INDEX, 2'b00};
  localparam logic [17:0] FLAG_ADDR = {FLAG_INDEX, 2'b00};
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [7:0] FLAG_RESET = 8'h00;
  localparam int BIT_SPARE = 0;
  localparam int BIT_DELIMITER_SEEN = 1;
  localparam int BIT_RX_FIFO_LEVEL = 2;
  localparam int BIT_SOURCE_SEARCH_COMPLETE = 3;
  localparam int BIT_SOURCE_HIT = 4;
  localparam int BIT_FRAME_FILTER_PASS = 5;
  localparam int BIT_RX_FRAME_DONE = 6;
  localparam int BIT_RX_ENABLE_CLEARED = 7;
  typedef struct packed {
    logic rxEnableCleared;
    logic rxFrameDone;
    logic frameFilterPass;
    logic sourceHit;
    logic sourceSearchComplete;
    logic rxFifoLevel;
    logic delimiterSeen;
    logic spareBit0;
  } event_vec_t;
  typedef struct packed {
    logic read;
    logic write;
    logic [17:0] address;
    logic [31:0] writedata;
  } bus_req_t;
endpackage

/* File: rtl/event_flag_bank.sv */
`timescale 1ns/1ns
module event_flag_bank #(
  parameter int WIDTH = 8
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [WIDTH-1:0] setPulse,
  input wire logic [WIDTH-1:0] clearMask,
  output logic [WIDTH-1:0] flags
);
  logic [WIDTH-1:0] next_flags;
  initial begin
    if (WIDTH < 1) $error("WIDTH must be at least one");
  end
  // Set beats clear so no event is lost
  generate
    for (genvar i = 0; i < WIDTH; i++) begin : gBit
      always_comb begin
        next_flags[i] = setPulse[i] | (flags[i] & ~clearMask[i]);
      end
    end
  endgenerate
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      flags <= '0;
    end else begin
      flags <= next_flags;
    end
  end
endmodule

/* File: rtl/rf_event_mask_bank0.sv */
`timescale 1ns/1ns
module rf_event_mask_bank0 (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [17:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire rf_event_mask_pkg::event_vec_t eventIn,
  output logic radioIrq
);
  logic [7:0] rfEventMask0;
  logic [7:0] next_rfEventMask0;
  logic [7:0] flags;
  logic [7:0] clearMask;
  logic [31:0] next_readdata;
  logic next_waitrequest;
  logic next_radioIrq;
  logic accept;
  logic request;
  logic maskSel;
  logic flagSel;
  logic writeLane0;

  // Address decode is shared by the write path and the read path
  function automatic logic hit(input logic [17:0] a, input logic [17:0] b);
    hit = (a == b);
  endfunction

  // Either strobe counts as a pending request
  assign request = read | write;

  // Accepting edge is the single cycle with waitrequest low
  assign accept = request & ~waitrequest; // Master still holds the request here

  // Decoded selects, one per mapped register
  assign maskSel = hit(address, rf_event_mask_pkg::MASK_ADDR);
  assign flagSel = hit(address, rf_event_mask_pkg::FLAG_ADDR);

  // Only lane 0 carries register bits; other lanes alone write nothing
  assign writeLane0 = write & byteenable[0];

  event_flag_bank #(
    .WIDTH(rf_event_mask_pkg::EVENT_COUNT)
  ) uFlags (
    .mclk(mclk),
    .resetn(resetn),
    .setPulse(eventIn),
    .clearMask(clearMask),
    .flags(flags)
  );

  // Register writes take effect on the accepting edge only
  always_comb begin
    next_rfEventMask0 = rfEventMask0;
    clearMask = 8'h00;
    if (accept && writeLane0) begin
      if (maskSel) begin
        next_rfEventMask0 = writedata[7:0];
      end
      if (flagSel) begin
        clearMask = writedata[7:0];
      end
    end
  end

  // Read data prepared in the wait cycle, so they stand at the accepting edge
  // Unmapped reads return zero, upper bits always zero
  always_comb begin
    next_readdata = 32'h0000_0000;
    if (read && waitrequest) begin
      if (maskSel) begin
        next_readdata = {24'h00_0000, rfEventMask0};
      end else if (flagSel) begin
        next_readdata = {24'h00_0000, flags};
      end
    end
  end

  // Handshake: a request seen with waitrequest high earns one low cycle
  always_comb begin
    next_waitrequest = ~(request & waitrequest);
  end

  // Level request, one cycle behind the flags; unmasked source only
  always_comb begin
    next_radioIrq = |(flags & rfEventMask0);
  end

  // Mask register; reset leaves every source disabled
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rfEventMask0 <= rf_event_mask_pkg::MASK_RESET;
    end else begin
      rfEventMask0 <= next_rfEventMask0;
    end
  end

  // Bus answer registers; waitrequest idles high
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      readdata <= 32'h0000_0000;
      waitrequest <= 1'b1;
    end else begin
      readdata <= next_readdata;
      waitrequest <= next_waitrequest;
    end
  end

  // Interrupt registered so the pin never glitches during decode
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      radioIrq <= 1'b0;
    end else begin
      radioIrq <= next_radioIrq;
    end
  end

  a_irq_needs_enable: assert property (@(posedge mclk) disable iff (!resetn)
    radioIrq |-> $past(|(flags & rfEventMask0)))
    else $error("irq without enabled flag");
  a_irq_follows: assert property (@(posedge mclk) disable iff (!resetn)
    (|(flags & rfEventMask0)) |=> radioIrq)
    else $error("irq missing");
  a_mask_bit7_gates: assert property (@(posedge mclk) disable iff (!resetn)
    (flags == 8'h80 && !rfEventMask0[7]) |=> !radioIrq)
    else $error("bit 7 not gating");
  a_mask_bit6_gates: assert property (@(posedge mclk) disable iff (!resetn)
    (flags == 8'h40 && rfEventMask0 == 8'h40) |=> radioIrq)
    else $error("bit 6 not gating");
  a_mask_bit5_gates: assert property (@(posedge mclk) disable iff (!resetn)
    (flags == 8'h20 && !rfEventMask0[5]) |=> !radioIrq)
    else $error("bit 5 not gating");
  a_mask_bit2_gates: assert property (@(posedge mclk) disable iff (!resetn)
    (flags == 8'h04 && rfEventMask0 == 8'h04) |=> radioIrq)
    else $error("bit 2 not gating");
  a_mask_bit1_gates: assert property (@(posedge mclk) disable iff (!resetn)
    (flags == 8'h02 && !rfEventMask0[1]) |=> !radioIrq)
    else $error("bit 1 not gating");
  a_mask_write_lands: assert property (@(posedge mclk) disable iff (!resetn)
    (write && !waitrequest && byteenable[0] && address == rf_event_mask_pkg::MASK_ADDR)
    |=> rfEventMask0 == $past(writedata[7:0]))
    else $error("mask write lost");
  a_event_sets_flag: assert property (@(posedge mclk) disable iff (!resetn)
    eventIn[4] |=> flags[4])
    else $error("event flag not set");
  a_wait_one_cycle: assert property (@(posedge mclk) disable iff (!resetn)
    (read || write) && waitrequest |=> !waitrequest)
    else $error("answer late");

  c_irq_raised: cover property (@(posedge mclk) disable iff (!resetn) $rose(radioIrq));
  c_mask_read: cover property (@(posedge mclk) disable iff (!resetn)
    read && !waitrequest && address == rf_event_mask_pkg::MASK_ADDR);
  c_flag_clear: cover property (@(posedge mclk) disable iff (!resetn)
    write && !waitrequest && address == rf_event_mask_pkg::FLAG_ADDR);
  c_event_masked: cover property (@(posedge mclk) disable iff (!resetn)
    (|eventIn) && rfEventMask0 == 8'h00);
  c_read_then_write: cover property (@(posedge mclk) disable iff (!resetn)
    (read && !waitrequest) ##2 write);

  // Source-match bits: bit 4 must block and bit 3 must enable like every other source
  a_mask_bit4_gates: assert property (@(posedge mclk) disable iff (!resetn)
    (flags == 8'h10 && !rfEventMask0[4]) |=> !radioIrq)
    else $error("bit 4 not gating");

  a_mask_bit3_enables: assert property (@(posedge mclk) disable iff (!resetn)
    (flags == 8'h08 && rfEventMask0 == 8'h08) |=> radioIrq)
    else $error("bit 3 not enabling");

  // Enabling side of bits 7, 5 and 1 checked for gating above, so a stuck-low gate is caught too
  a_mask_bit7_enables: assert property (@(posedge mclk) disable iff (!resetn)
    (flags == 8'h80 && rfEventMask0 == 8'h80) |=> radioIrq)
    else $error("bit 7 not enabling");

  a_mask_bit5_enables: assert property (@(posedge mclk) disable iff (!resetn)
    (flags == 8'h20 && rfEventMask0 == 8'h20) |=> radioIrq)
    else $error("bit 5 not enabling");

  a_mask_bit1_enables: assert property (@(posedge mclk) disable iff (!resetn)
    (flags == 8'h02 && rfEventMask0 == 8'h02) |=> radioIrq)
    else $error("bit 1 not enabling");

  // Blocking side of bits 6 and 2, checked for enabling above
  a_mask_bit6_blocks: assert property (@(posedge mclk) disable iff (!resetn)
    (flags == 8'h40 && !rfEventMask0[6]) |=> !radioIrq)
    else $error("bit 6 not blocking");

  a_mask_bit2_blocks: assert property (@(posedge mclk) disable iff (!resetn)
    (flags == 8'h04 && !rfEventMask0[2]) |=> !radioIrq)
    else $error("bit 2 not blocking");

  // Mask only moves on an accepted write
  a_mask_held_idle: assert property (@(posedge mclk) disable iff (!resetn)
    !(write && !waitrequest) |=> $stable(rfEventMask0))
    else $error("mask changed without write");

  // Readback of the mask stands while waitrequest is low
  a_mask_read_value: assert property (@(posedge mclk) disable iff (!resetn)
    (read && waitrequest && address == rf_event_mask_pkg::MASK_ADDR)
    |=> readdata == {24'h00_0000, $past(rfEventMask0)})
    else $error("mask readback wrong");

  // Outside the answer cycle the data bus rests at zero
  a_readdata_rests: assert property (@(posedge mclk) disable iff (!resetn)
    waitrequest |-> readdata == 32'h0000_0000)
    else $error("readdata not zero when idle");

  // Write one clears, unless a new event lands in the same cycle
  a_flag_clear_works: assert property (@(posedge mclk) disable iff (!resetn)
    (write && !waitrequest && byteenable[0] && address == rf_event_mask_pkg::FLAG_ADDR
    && eventIn == 8'h00) |=> (flags & $past(writedata[7:0])) == 8'h00)
    else $error("flag not cleared");

  // No request, no answer
  a_no_spurious_answer: assert property (@(posedge mclk) disable iff (!resetn)
    !(read || write) |=> waitrequest)
    else $error("answer without request");
endmodule

/* File: test/tb.sv */
`timescale 1ns/1ns
module tb;
  logic mclk = 0, resetn = 0, read = 0, write = 0, radioIrq, waitrequest;
  logic [17:0] address = '0;
  logic [31:0] writedata = '0, readdata, rdv, lfsr = 32'hc74f_3215;
  logic [3:0] byteenable = 4'hf;
  logic [7:0] m;
  rf_event_mask_pkg::event_vec_t eventIn = '0;
  int num_errors = 0, comparisons = 0, b;
  rf_event_mask_bank0 i_rf_event_mask_bank0 (.mclk(mclk), .resetn(resetn), .address(address),
    .read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
    .readdata(readdata), .waitrequest(waitrequest), .eventIn(eventIn), .radioIrq(radioIrq));
  initial forever #10 mclk = ~mclk;
  function automatic logic [31:0] nextRand(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Holds the request until the edge with waitrequest low; data taken for that edge
  task automatic access(input logic rd, input logic [17:0] a, input logic [31:0] d);
    int n;
    logic busy;
    n = 0;
    busy = 1'b1;
    read <= rd;
    write <= !rd;
    address <= a;
    writedata <= d;
    while (busy && n < 50) begin
      @(negedge mclk);
      busy = (waitrequest !== 1'b0);
      rdv = readdata;
      @(posedge mclk);
      n++;
    end
    if (busy) begin
      num_errors++;
      summarize();
    end
    read <= 1'b0;
    write <= 1'b0;
    @(posedge mclk);
  endtask
  // Watchdog, far beyond the few hundred cycles the tests need
  initial begin
    repeat (5000) @(posedge mclk);
    num_errors++;
    summarize();
  end
  initial begin
    repeat (10) @(posedge mclk);
    resetn <= 1'b1;
    @(posedge mclk);
    access(1'b1, rf_event_mask_pkg::MASK_ADDR, '0);
    check("mask reset", rdv, 32'h0000_0000);
    access(1'b1, 18'h0_0010, '0);
    check("unmapped read", rdv, 32'h0000_0000);
    byteenable <= 4'he;
    access(1'b0, rf_event_mask_pkg::MASK_ADDR, 32'h0000_00ff);
    byteenable <= 4'hf;
    access(1'b0, 18'h0_0010, 32'h0000_00ff);
    access(1'b1, rf_event_mask_pkg::MASK_ADDR, '0);
    check("lane 0 off", rdv, 32'h0000_0000);
    // First pass with the source's bit cleared, second pass with it set
    for (int i = 0; i < 16; i++) begin
      b = i % 8;
      lfsr = nextRand(lfsr);
      m = lfsr[7:0];
      m[b] = i[3];
      access(1'b0, rf_event_mask_pkg::MASK_ADDR, {lfsr[31:8], m});
      access(1'b1, rf_event_mask_pkg::MASK_ADDR, '0);
      check("mask readback", rdv, {24'h00_0000, m});
      eventIn <= rf_event_mask_pkg::event_vec_t'(8'h01 << b);
      @(posedge mclk);
      eventIn <= '0;
      repeat (3) @(posedge mclk);
      check("irq gated", {31'h0, radioIrq}, {31'h0, m[b]});
      access(1'b1, rf_event_mask_pkg::FLAG_ADDR, '0);
      check("flag latched", rdv, 32'h0000_0001 << b);
      access(1'b0, rf_event_mask_pkg::FLAG_ADDR, 32'h0000_0001 << b);
      repeat (2) @(posedge mclk);
      check("irq cleared", {31'h0, radioIrq}, 32'h0000_0000);
      $display("test bit %0d mask %h done", b, m);
    end
    summarize();
  end
endmodule
